// File: bench/pin_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module pin_monitor
#(
  parameter int SPAN = 160
)
(
  // Clock
  input  wire logic        mclk,
  // Shared pin as the block drives it
  input  wire logic        pin_out,
  input  wire logic        pin_oe_n,
  // Level an outside jumper puts on the pin
  input  wire logic        cfg_drive,
  // Measurement control
  input  wire logic        start,
  output var  logic        pin_in,
  output var  logic        done,
  output var  logic [15:0] highs
);
  int          n = 0;
  logic [15:0] acc;
  // Wire level: the block wins while it drives, else the jumper
  assign pin_in = pin_oe_n ? cfg_drive : pin_out;
  // Counts driven-high cycles over exactly one PWM period
  always @(posedge mclk)
  begin
    done <= 1'b0;
    if (start)
    begin
      n   <= SPAN;
      acc <= 16'h0000;
    end
    else if (n > 0)
    begin
      acc <= acc + 16'(pin_in & ~pin_oe_n);
      n   <= n - 1;
      if (n == 1)
      begin
        done  <= 1'b1;
        highs <= acc + 16'(pin_in & ~pin_oe_n);
      end
    end
  end
endmodule
`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import rssi_pwm_pkg::*;
  localparam int STP = 4;
  logic        mclk, reset, pin_in, pin_out, pin_oe_n, cfg_level, cfg_drive, m_start, m_done;
  logic [15:0] m_highs;
  logic [31:0] rs = 32'hDA44;
  logic [15:0] expq[$];
  pkt_t        pkt;
  cmd_t        cmd;
  rsp_t        rsp;
  int          miscompares = 0;
  int          total_checks = 0;
  int          m;
  int          margins[7] = '{10, 20, 30, 0, 5, 100, 14};

  rssi_pwm_indicator #(.STEP_CYC(STP), .HOLD_CYC(20), .CFG_CYC(10)) uut
  (.mclk(mclk), .reset(reset), .pkt(pkt), .cmd(cmd), .rsp(rsp), .pin_in(pin_in),
   .pin_out(pin_out), .pin_oe_n(pin_oe_n), .cfg_level(cfg_level));
  pin_monitor #(.SPAN(STP * 40)) mon
  (.mclk(mclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .cfg_drive(cfg_drive),
   .start(m_start), .pin_in(pin_in), .done(m_done), .highs(m_highs));

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    if (miscompares == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Expected step count, rounded to the nearest step and capped at 95 percent
  function automatic int duty(input int v);
    int d;
    d = (v <= 10) ? (8 * v + 5) / 10 : (6 * v + 25) / 10;
    return (d > 38) ? 38 : d;
  endfunction

  task automatic command(input logic w, input logic [7:0] code, input logic [7:0] d, input logic [7:0] e);
    if (code == CMD_HOLD_TIME)
      expq.push_back({8'h00, e});
    cmd = '{valid: 1'b1, write: w, code: code, wdata: d};
    tick(1);
    cmd.valid = 1'b0;
    tick(2);
  endtask

  task automatic packet(input int v);
    pkt = '{valid: 1'b1, margin_db: 8'(v)};
    tick(1);
    pkt.valid = 1'b0;
  endtask

  task automatic measure(input int steps);
    expq.push_back(16'(steps * STP));
    m_start = 1'b1;
    tick(1);
    m_start = 1'b0;
    tick(STP * 40 + 3);
  endtask

  // Results are compared against notes in the order they were made
  // Sampled mid-cycle, where a one-cycle answer has settled
  always @(negedge mclk)
    if (!reset && rsp.valid === 1'b1)
      chk({8'h00, rsp.data}, (expq.size() > 0) ? expq.pop_front() : 16'hFFFF);
    else if (!reset && m_done === 1'b1)
      chk(m_highs, (expq.size() > 0) ? expq.pop_front() : 16'hFFFF);

  initial
  begin
    #100000;
    miscompares++;
    close_out();
  end

  initial
  begin
    reset = 1'b1;
    pkt = '0;
    cmd = '0;
    cfg_drive = 1'b1;
    m_start = 1'b0;
    tick(4);
    reset = 1'b0;
    tick(1);
    chk(16'(pin_oe_n), 16'h0001);
    chk(16'(pin_out), 16'h0000);
    command(1'b0, CMD_HOLD_TIME, 8'h00, HOLD_RESET);
    chk(16'(cfg_level), 16'h0001);
    // Window is 0x20 units of 10 cycles from the first edge after release
    tick(316);
    chk(16'(pin_oe_n), 16'h0001);
    tick(1);
    chk(16'(pin_oe_n), 16'h0000);
    measure(0);
    for (int i = 0; i < 10; i++)
    begin
      rs = xs(rs);
      m = (i < 7) ? margins[i] : int'(rs[5:0]);
      packet(m);
      tick(8);
      measure(duty(m));
    end
    command(1'b1, 8'h21, 8'h05, 8'h00);
    command(1'b1, CMD_HOLD_TIME, 8'h02, 8'h02);
    packet(20);
    tick(50);
    measure(0);
    command(1'b1, CMD_HOLD_TIME, HOLD_FOREVER, HOLD_FOREVER);
    packet(30);
    // Longer than 0xFE units would last, so a missing permanent mode shows up
    tick(5200);
    measure(20);
    // Reset in mid-run must take a driven pin back to a low input
    reset = 1'b1;
    tick(4);
    reset = 1'b0;
    chk(16'(pin_out), 16'h0000);
    chk(16'(pin_oe_n), 16'h0001);
    command(1'b0, CMD_HOLD_TIME, 8'h00, HOLD_RESET);
    command(1'b1, CMD_HOLD_TIME, HOLD_OFF, HOLD_OFF);
    cfg_drive = 1'b0;
    tick(3);
    chk(16'(pin_oe_n), 16'h0001);
    chk(16'(cfg_level), 16'h0000);
    command(1'b1, CMD_HOLD_TIME, HOLD_RESET, HOLD_RESET);
    chk(16'(pin_oe_n), 16'h0000);
    chk(16'(expq.size()), 16'h0000);
    close_out();
  end
endmodule
`default_nettype wire

// File: rtl/rssi_pwm_indicator.sv
`timescale 1ns/100ps
`default_nettype none
module rssi_pwm_indicator
#(
  parameter int unsigned STEP_CYC  = rssi_pwm_pkg::STEP_CYCLES,
  parameter int unsigned HOLD_CYC  = rssi_pwm_pkg::HOLD_UNIT_CYC,
  parameter int unsigned CFG_CYC   = rssi_pwm_pkg::CFG_UNIT_CYC
)
(
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               reset,
  // Received packet strength
  input  wire rssi_pwm_pkg::pkt_t pkt,
  // Command port
  input  wire rssi_pwm_pkg::cmd_t cmd,
  output var  rssi_pwm_pkg::rsp_t rsp,
  // Shared configuration and strength pin
  input  wire logic               pin_in,
  output var  logic               pin_out,
  output var  logic               pin_oe_n,
  output var  logic               cfg_level
);
  import rssi_pwm_pkg::*;

  // ----------------------------------------
  // Hold-time register and command answers
  // ----------------------------------------
  logic [7:0] hold_q;
  logic [7:0] hold_d;
  rsp_t       rsp_q;
  rsp_t       rsp_d;
  logic       hit;

  always_comb
  begin
    hit    = cmd.valid && (cmd.code == CMD_HOLD_TIME);
    hold_d = hold_q;
    rsp_d  = '0;
    if (hit && cmd.write)
    begin
      hold_d = cmd.wdata;
    end
    // Reads and writes both answer with the setting now in force
    if (hit)
    begin
      rsp_d.valid = 1'b1;
      rsp_d.data  = hold_d;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      hold_q <= HOLD_RESET;
      rsp_q  <= '0;
    end
    else
    begin
      hold_q <= hold_d;
      rsp_q  <= rsp_d;
    end
  end

  assign rsp = rsp_q;

  // ----------------------------------------
  // Margin to duty steps
  // ----------------------------------------
  logic [10:0] scaled;
  logic [7:0]  quot;
  logic [5:0]  steps;

  // Two line segments through the table points, rounded by adding half a divisor
  always_comb
  begin
    if (pkt.margin_db <= KNEE_DB)
    begin
      scaled = 11'(({3'h0, pkt.margin_db} << 3) + 11'h005);
    end
    else
    begin
      scaled = 11'(({3'h0, pkt.margin_db} * 11'h006) + 11'h019);
    end
    quot = 8'(scaled / 11'h00A);
    if (pkt.margin_db == 8'h00)
    begin
      steps = 6'h00;
    end
    else if (quot > {2'h0, DUTY_MAX_STEPS})
    begin
      steps = DUTY_MAX_STEPS;
    end
    else
    begin
      steps = quot[5:0];
    end
  end

  // ----------------------------------------
  // Pin ownership and hold timing
  // ----------------------------------------
  ind_state_t          state_q;
  ind_state_t          state_d;
  logic [TICK_W-1:0]   tick_q;
  logic [TICK_W-1:0]   tick_d;
  logic [7:0]          unit_q;
  logic [7:0]          unit_d;
  logic [5:0]          duty_q;
  logic [5:0]          duty_d;
  logic                unit_end;
  logic [TICK_W-1:0]   tick_lim;

  always_comb
  begin
    state_d  = state_q;
    duty_d   = duty_q;
    tick_lim = (state_q == ST_CFG_WINDOW) ? TICK_W'(CFG_CYC - 1) : TICK_W'(HOLD_CYC - 1);
    unit_end = (tick_q == tick_lim);
    tick_d   = unit_end ? '0 : TICK_W'(tick_q + 1'b1);
    unit_d   = unit_end ? 8'(unit_q + 1'b1) : unit_q;
    if (pkt.valid)
    begin
      duty_d = steps;
    end
    case (state_q)
      ST_CFG_WINDOW:
      begin
        // Pin listens for configuration level for hold_q milliseconds
        if (unit_end && (unit_d >= hold_q))
        begin
          state_d = ST_WAIT_PKT;
          tick_d  = '0;
          unit_d  = '0;
        end
      end
      ST_WAIT_PKT, ST_IDLE_LOW:
      begin
        tick_d = '0;
        unit_d = '0;
        if (pkt.valid)
        begin
          state_d = ST_ACTIVE;
        end
      end
      ST_ACTIVE:
      begin
        if (pkt.valid)
        begin
          tick_d = '0;
          unit_d = '0;
        end
        else if (hold_q == HOLD_FOREVER)
        begin
          tick_d = '0;
          unit_d = '0;
        end
        else if (unit_end && (unit_d >= hold_q))
        begin
          state_d = ST_IDLE_LOW;
          duty_d  = 6'h00;
        end
      end
      default:
      begin
        tick_d = '0;
        unit_d = '0;
      end
    endcase
    // A zero setting takes the pin back as input at any time
    if (hold_d == HOLD_OFF)
    begin
      state_d = ST_DISABLED;
      duty_d  = 6'h00;
      tick_d  = '0;
      unit_d  = '0;
    end
    else if (state_q == ST_DISABLED)
    begin
      state_d = ST_WAIT_PKT;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state_q <= ST_CFG_WINDOW;
      tick_q  <= '0;
      unit_q  <= '0;
      duty_q  <= 6'h00;
    end
    else
    begin
      state_q <= state_d;
      tick_q  <= tick_d;
      unit_q  <= unit_d;
      duty_q  <= duty_d;
    end
  end

  // ----------------------------------------
  // PWM step sequencer and pin drive
  // ----------------------------------------
  logic [TICK_W-1:0] sub_q;
  logic [TICK_W-1:0] sub_d;
  logic [5:0]        step_q;
  logic [5:0]        step_d;
  logic              pin_out_q;
  logic              pin_out_d;
  logic              oe_n_q;
  logic              oe_n_d;
  logic              cfg_q;
  logic              cfg_d;

  // Free-running period keeps the pulse phase independent of packet timing
  always_comb
  begin
    sub_d  = TICK_W'(sub_q + 1'b1);
    step_d = step_q;
    if (sub_q == TICK_W'(STEP_CYC - 1))
    begin
      sub_d  = '0;
      step_d = (step_q == STEP_LAST) ? 6'h00 : 6'(step_q + 1'b1);
    end
    oe_n_d    = (state_q == ST_CFG_WINDOW) || (state_q == ST_DISABLED);
    pin_out_d = (state_q == ST_ACTIVE) && (step_q < duty_q);
    cfg_d     = oe_n_q ? pin_in : cfg_q;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      sub_q     <= '0;
      step_q    <= 6'h00;
      pin_out_q <= 1'b0;
      oe_n_q    <= 1'b1;
      cfg_q     <= 1'b0;
    end
    else
    begin
      sub_q     <= sub_d;
      step_q    <= step_d;
      pin_out_q <= pin_out_d;
      oe_n_q    <= oe_n_d;
      cfg_q     <= cfg_d;
    end
  end

  assign pin_out   = pin_out_q;
  assign pin_oe_n  = oe_n_q;
  assign cfg_level = cfg_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  AST_DUTY_CAP: assert property (duty_q <= DUTY_MAX_STEPS)
    else $error("duty above 95 percent");

  AST_ZERO_MARGIN: assert property (pkt.valid && pkt.margin_db == 8'h00 |=> duty_q == 6'h00)
    else $error("zero margin gave nonzero duty");

  AST_STEP_WRAP: assert property (step_q <= STEP_LAST)
    else $error("step index beyond period");

  AST_MAP_20DB: assert property (pkt.valid && pkt.margin_db == 8'h14 && hold_d != HOLD_OFF
    |=> duty_q == 6'h0E)
    else $error("20 dB did not give 35 percent");

  AST_PKT_ACTIVATES: assert property ((state_q == ST_WAIT_PKT || state_q == ST_IDLE_LOW)
    && pkt.valid && hold_d != HOLD_OFF |=> state_q == ST_ACTIVE)
    else $error("packet did not activate output");

  AST_LOW_WHEN_IDLE: assert property (state_q != ST_ACTIVE |=> !pin_out_q)
    else $error("pin high outside active state");

  AST_RESET_LOW: assert property (@(posedge mclk) $past(reset) |-> !pin_out_q && oe_n_q)
    else $error("pin not low input after reset");

  AST_FOREVER: assert property (state_q == ST_ACTIVE && hold_q == HOLD_FOREVER && !cmd.valid
    |=> state_q == ST_ACTIVE)
    else $error("permanent hold timed out");

  AST_CMD_ANSWER: assert property (cmd.valid && !cmd.write && cmd.code == CMD_HOLD_TIME
    |=> rsp_q.valid && rsp_q.data == $past(hold_q))
    else $error("hold read answered wrongly");

  AST_DISABLED_INPUT: assert property (state_q == ST_DISABLED |=> oe_n_q && !pin_out_q)
    else $error("disabled pin still driven");

  AST_WINDOW_EXIT: assert property (state_q == ST_CFG_WINDOW ##1 state_q == ST_WAIT_PKT
    |-> $past(unit_end))
    else $error("config window ended early");

  COV_ACTIVE: cover property (state_q == ST_WAIT_PKT ##1 state_q == ST_ACTIVE);
  COV_TIMEOUT: cover property (state_q == ST_ACTIVE ##1 state_q == ST_IDLE_LOW);
  COV_DISABLE: cover property (state_q != ST_DISABLED ##1 state_q == ST_DISABLED);
  COV_HIGH: cover property (pin_out_q && !oe_n_q);

endmodule
`default_nettype wire

// File: rtl/rssi_pwm_pkg.sv
`default_nettype none
package rssi_pwm_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 4;
  localparam int unsigned PWM_PERIOD_NS  = 8_320_000;
  localparam int unsigned PWM_STEPS      = 40;
  localparam int unsigned STEP_CYCLES    = PWM_PERIOD_NS / CLK_PERIOD_NS / PWM_STEPS;
  localparam int unsigned HOLD_UNIT_MS   = 100;
  localparam int unsigned HOLD_UNIT_CYC  = HOLD_UNIT_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int unsigned CFG_UNIT_MS    = 1;
  localparam int unsigned CFG_UNIT_CYC   = CFG_UNIT_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int unsigned TICK_W         = 25;

  // ----------------------------------------
  // Duty scale
  // ----------------------------------------
  localparam logic [5:0] DUTY_MAX_STEPS  = 6'h26;
  localparam logic [5:0] STEP_LAST      = 6'h27;
  localparam logic [7:0] KNEE_DB        = 8'h0A;

  // ----------------------------------------
  // Register and commands
  // ----------------------------------------
  localparam logic [7:0] CMD_HOLD_TIME   = 8'h22;
  localparam logic [7:0] HOLD_RESET      = 8'h20;
  localparam logic [7:0] HOLD_FOREVER    = 8'hFF;
  localparam logic [7:0] HOLD_OFF        = 8'h00;

  typedef enum logic [2:0] {
    ST_CFG_WINDOW,
    ST_WAIT_PKT,
    ST_ACTIVE,
    ST_IDLE_LOW,
    ST_DISABLED
  } ind_state_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] margin_db;
  } pkt_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] code;
    logic [7:0] wdata;
  } cmd_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } rsp_t;

endpackage
`default_nettype wire
